// ===== pkg/pmwe_pkg.sv
`default_nettype none
package pmwe_pkg;

    localparam int NUM_WIN   = 2;
    localparam int NUM_LINES = 6;
    localparam int CPU_AW    = 16;
    localparam int WB_AW     = 8;
    localparam int WB_DW     = 32;

    // Register byte offsets on the bus.
    localparam logic [WB_AW-1:0] OFS_LINE_ASSIGN = 8'h00;
    localparam logic [WB_AW-1:0] OFS_WIN_SIZE    = 8'h04;
    localparam logic [WB_AW-1:0] OFS_WIN_BASE    = 8'h08;
    localparam logic [WB_AW-1:0] OFS_BANK1       = 8'h0c;
    localparam logic [WB_AW-1:0] OFS_BANK2       = 8'h10;
    localparam logic [WB_AW-1:0] OFS_CONTROL     = 8'h14;
    localparam logic [WB_AW-1:0] OFS_STATUS      = 8'h18;

    // Field positions.
    localparam int POS_SIZE1   = 0;
    localparam int POS_SIZE2   = 2;
    localparam int POS_BASE1   = 0;
    localparam int POS_BASE2   = 4;
    localparam int POS_ROM_EN  = 0;
    localparam int POS_ROM_LOW = 1;
    localparam int POS_EXP_EN  = 2;
    localparam int POS_ST_HIT1 = 0;
    localparam int POS_ST_HIT2 = 1;
    localparam int POS_ST_EXT  = 2;
    localparam int POS_ST_ON   = 3;

    // Reset values.
    localparam logic [5:0] RST_LINE_ASSIGN = 6'h00;
    localparam logic [1:0] RST_SIZE        = 2'h0;
    localparam logic [2:0] RST_BASE        = 3'h0;
    localparam logic [5:0] RST_BANK        = 6'h00;
    localparam logic       RST_ROM_EN      = 1'b1;
    localparam logic       RST_ROM_LOW     = 1'b0;
    localparam logic       RST_EXP_EN      = 1'b0;

    // Window size codes.
    localparam logic [1:0] SZ_OFF = 2'h0;
    localparam logic [1:0] SZ_8K  = 2'h1;
    localparam logic [1:0] SZ_16K = 2'h2;
    localparam logic [1:0] SZ_32K = 2'h3;

    localparam logic [1:0] MID_BASE_MSB = 2'h1;
    localparam logic [CPU_AW-1:0] VEC_EXT_ADDR = 16'h7ffe;

endpackage
`default_nettype wire

// ===== logic/pmwe_window_decode.sv
`timescale 1ns/10ps
`default_nettype none
module pmwe_window_decode
    import pmwe_pkg::*;
(
    input  wire logic [1:0]          winSize,
    input  wire logic [2:0]          winBase,
    input  wire logic [CPU_AW-1:0]   addr,
    output logic                     hit,
    output logic                     midBase,
    output logic [NUM_LINES-1:0]     useMask
);
    always_comb begin
        midBase = (winSize == SZ_32K) && (winBase[2:1] == MID_BASE_MSB);
        hit     = 1'b0;
        useMask = 6'h00;
        case (winSize)
            SZ_8K: begin
                hit     = (addr[15:13] == winBase);
                useMask = 6'h3f;
            end
            SZ_16K: begin
                hit     = (addr[15:14] == winBase[2:1]);
                useMask = 6'h3e;
            end
            SZ_32K: begin
                useMask = 6'h3c;
                if (midBase) begin
                    hit = (addr[15:14] == 2'h1) || (addr[15:14] == 2'h2);
                end else begin
                    hit = (addr[15] == winBase[2]);
                end
            end
            default: begin
                hit     = 1'b0;
                useMask = 6'h00;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== logic/pmwe_top.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Two windows, each disabled or 8, 16 or 32 Kbytes in size.
// - Inside an active window the bank lines carry the bank number and low CPU bits the offset.
// - A shared pin drives a bank line only when its assignment bit is set, else it is GPIO.
// - Assigned low three bank lines replace CPU address bits 15 to 13.
// - Offset bits are 12:0, 13:0 or 14:0 for 8K, 16K or 32K windows.
// - A 32K window at 0x4000 drives inverted CPU bit 14 on bank line 1 while active.
// - Window one wins where the windows overlap.
// - Internal registers, RAM and EEPROM are served on chip in every bank.
// - On-chip ROM is served only in banks whose upper three bank bits are zero.
// - The reset vector comes from ROM unless ROM is off or relocated low.
// - An external vector fetch with expansion on reads 0x7ffe and 0x7fff.
// - Size codes are 00 off, 01 8K, 10 16K and 11 32K.
// - An assigned low line that no window uses still drives the CPU bit; lines 3 to 5 drive zero.
module pmwe_top
    import pmwe_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [pmwe_pkg::WB_AW-1:0]   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [pmwe_pkg::WB_DW-1:0]   wb_dat_i,
    output logic      [pmwe_pkg::WB_DW-1:0]   wb_dat_o,
    output logic                              wb_ack_o,
    input  wire logic [pmwe_pkg::CPU_AW-1:0]  cpuAddr,
    input  wire logic                         cpuVectorFetch,
    input  wire logic                         onChipHit,
    input  wire logic                         romHit,
    input  wire logic [pmwe_pkg::NUM_LINES-1:0] gpioDrive,
    input  wire logic [pmwe_pkg::NUM_LINES-1:0] gpioOe,
    input  wire logic [pmwe_pkg::NUM_LINES-1:0] pinIn,
    output logic      [pmwe_pkg::NUM_LINES-1:0] gpioIn,
    output logic      [pmwe_pkg::NUM_LINES-1:0] pinOut,
    output logic      [pmwe_pkg::NUM_LINES-1:0] pinOe,
    output logic      [pmwe_pkg::CPU_AW-1:0]  memAddr,
    output logic                              externalSel,
    output logic                              onChipSel,
    output logic                              win1Active,
    output logic                              win2Active
);
    import pmwe_pkg::*;

    typedef struct packed {
        logic [NUM_LINES-1:0] lineAssign;
        logic [1:0]           size1;
        logic [1:0]           size2;
        logic [2:0]           base1;
        logic [2:0]           base2;
        logic [NUM_LINES-1:0] bank1;
        logic [NUM_LINES-1:0] bank2;
        logic                 romEn;
        logic                 romLow;
        logic                 expEn;
        logic                 ack;
        logic [WB_DW-1:0]     rdData;
        logic [CPU_AW-1:0]    memAddr;
        logic [NUM_LINES-1:0] pinOut;
        logic [NUM_LINES-1:0] pinOe;
        logic                 extSel;
        logic                 onSel;
        logic                 hit1;
        logic                 hit2;
        logic [NUM_LINES-1:0] sync1;
        logic [NUM_LINES-1:0] sync2;
        logic [NUM_LINES-1:0] sync3;
        logic [NUM_LINES-1:0] gpioIn;
    } pmwe_state_s;

    pmwe_state_s st;
    pmwe_state_s nxt_st;

    logic                 vecExt;
    logic [CPU_AW-1:0]    effAddr;
    logic [1:0]           winSize [NUM_WIN];
    logic [2:0]           winBase [NUM_WIN];
    logic                 winHit  [NUM_WIN];
    logic                 winMid  [NUM_WIN];
    logic [NUM_LINES-1:0] winMask [NUM_WIN];
    logic                 selHit1;
    logic                 selHit2;
    logic                 anyHit;
    logic                 selMid;
    logic [NUM_LINES-1:0] selMask;
    logic [NUM_LINES-1:0] selBank;
    logic [NUM_LINES-1:0] cpuHigh;
    logic [NUM_LINES-1:0] lineVal;
    logic                 romOk;
    logic                 onChip;
    logic                 busReq;
    logic                 busWr;
    logic [NUM_LINES-1:0] syncEq;

    // Vector goes external when ROM is off or relocated.
    assign vecExt = cpuVectorFetch && (!st.romEn || st.romLow);

    assign effAddr = (vecExt && st.expEn)
                   ? {VEC_EXT_ADDR[CPU_AW-1:1], cpuAddr[0]}
                   : cpuAddr;

    assign winSize[0] = st.size1;
    assign winSize[1] = st.size2;
    assign winBase[0] = st.base1;
    assign winBase[1] = st.base2;

    genvar gw;
    generate
        for (gw = 0; gw < NUM_WIN; gw++) begin : g_win
            pmwe_window_decode u_dec (
                .winSize (winSize[gw]),
                .winBase (winBase[gw]),
                .addr    (effAddr),
                .hit     (winHit[gw]),
                .midBase (winMid[gw]),
                .useMask (winMask[gw])
            );
        end
    endgenerate

    assign selHit1 = winHit[0];
    assign selHit2 = winHit[1] && !winHit[0];
    assign anyHit  = selHit1 || selHit2;
    assign selMid  = selHit1 ? winMid[0] : winMid[1];
    assign selMask = selHit1 ? winMask[0] : (selHit2 ? winMask[1] : 6'h00);
    assign selBank = selHit1 ? st.bank1 : st.bank2;
    assign cpuHigh = {3'h0, effAddr[15:13]};

    // Bank bits from the current decode, registered onto the pins one cycle later.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            // Used lines carry the bank number.
            // Unused low lines carry the CPU bit, except line 1 in a 32K window at 0x4000, which carries inverted bit 14; upper lines carry zero.
            assign lineVal[gi] = (anyHit && selMask[gi]) ? selBank[gi]
                               : (gi == 1 && anyHit && selMid) ? ~effAddr[14]
                               : cpuHigh[gi];
        end
    endgenerate

    // ROM only in banks with upper bits zero.
    assign romOk  = romHit && st.romEn && !vecExt
                 && (!anyHit || (selBank[5:3] == 3'h0));
    assign onChip = onChipHit || romOk;

    assign busReq = wb_cyc_i && wb_stb_i && !st.ack;
    assign busWr  = busReq && wb_we_i && wb_sel_i[0];
    assign syncEq = ~(st.sync2 ^ st.sync3);

    always_comb begin
        nxt_st = st;
        nxt_st.ack = busReq;
        nxt_st.rdData = '0;
        if (busWr) begin
            if (wb_adr_i == OFS_LINE_ASSIGN) begin
                nxt_st.lineAssign = wb_dat_i[NUM_LINES-1:0];
            end else if (wb_adr_i == OFS_WIN_SIZE) begin
                nxt_st.size1 = wb_dat_i[POS_SIZE1 +: 2];
                nxt_st.size2 = wb_dat_i[POS_SIZE2 +: 2];
            end else if (wb_adr_i == OFS_WIN_BASE) begin
                nxt_st.base1 = wb_dat_i[POS_BASE1 +: 3];
                nxt_st.base2 = wb_dat_i[POS_BASE2 +: 3];
            end else if (wb_adr_i == OFS_BANK1) begin
                nxt_st.bank1 = wb_dat_i[NUM_LINES-1:0];
            end else if (wb_adr_i == OFS_BANK2) begin
                nxt_st.bank2 = wb_dat_i[NUM_LINES-1:0];
            end else if (wb_adr_i == OFS_CONTROL) begin
                nxt_st.romEn  = wb_dat_i[POS_ROM_EN];
                nxt_st.romLow = wb_dat_i[POS_ROM_LOW];
                nxt_st.expEn  = wb_dat_i[POS_EXP_EN];
            end
        end
        if (busReq && !wb_we_i) begin
            if (wb_adr_i == OFS_LINE_ASSIGN) begin
                nxt_st.rdData[NUM_LINES-1:0] = st.lineAssign;
            end else if (wb_adr_i == OFS_WIN_SIZE) begin
                nxt_st.rdData[POS_SIZE1 +: 2] = st.size1;
                nxt_st.rdData[POS_SIZE2 +: 2] = st.size2;
            end else if (wb_adr_i == OFS_WIN_BASE) begin
                nxt_st.rdData[POS_BASE1 +: 3] = st.base1;
                nxt_st.rdData[POS_BASE2 +: 3] = st.base2;
            end else if (wb_adr_i == OFS_BANK1) begin
                nxt_st.rdData[NUM_LINES-1:0] = st.bank1;
            end else if (wb_adr_i == OFS_BANK2) begin
                nxt_st.rdData[NUM_LINES-1:0] = st.bank2;
            end else if (wb_adr_i == OFS_CONTROL) begin
                nxt_st.rdData[POS_ROM_EN]  = st.romEn;
                nxt_st.rdData[POS_ROM_LOW] = st.romLow;
                nxt_st.rdData[POS_EXP_EN]  = st.expEn;
            end else if (wb_adr_i == OFS_STATUS) begin
                nxt_st.rdData[POS_ST_HIT1] = st.hit1;
                nxt_st.rdData[POS_ST_HIT2] = st.hit2;
                nxt_st.rdData[POS_ST_EXT]  = st.extSel;
                nxt_st.rdData[POS_ST_ON]   = st.onSel;
            end
        end
        // Assigned low lines replace CPU bits 15 to 13.
        nxt_st.memAddr = effAddr;
        for (int k = 0; k < 3; k++) begin
            if (st.lineAssign[k]) begin
                nxt_st.memAddr[13+k] = lineVal[k];
            end
        end
        // Pin ownership between bank line and GPIO.
        nxt_st.pinOut = (st.lineAssign & lineVal) | (~st.lineAssign & gpioDrive);
        nxt_st.pinOe  = st.lineAssign | gpioOe;
        nxt_st.extSel = !onChip;
        nxt_st.onSel  = onChip;
        nxt_st.hit1   = selHit1;
        nxt_st.hit2   = selHit2;
        nxt_st.sync1  = pinIn;
        nxt_st.sync2  = st.sync1;
        nxt_st.sync3  = st.sync2;
        nxt_st.gpioIn = (syncEq & st.sync3) | (~syncEq & st.gpioIn);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st            <= '0;
            st.lineAssign <= RST_LINE_ASSIGN;
            st.size1      <= RST_SIZE;
            st.size2      <= RST_SIZE;
            st.base1      <= RST_BASE;
            st.base2      <= RST_BASE;
            st.bank1      <= RST_BANK;
            st.bank2      <= RST_BANK;
            st.romEn      <= RST_ROM_EN;
            st.romLow     <= RST_ROM_LOW;
            st.expEn      <= RST_EXP_EN;
        end else begin
            st <= nxt_st;
        end
    end

    assign wb_dat_o    = st.rdData;
    assign wb_ack_o    = st.ack;
    assign gpioIn      = st.gpioIn;
    assign pinOut      = st.pinOut;
    assign pinOe       = st.pinOe;
    assign memAddr     = st.memAddr;
    assign externalSel = st.extSel;
    assign onChipSel   = st.onSel;
    assign win1Active  = st.hit1;
    assign win2Active  = st.hit2;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    ack_answer_a: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus request not answered in one cycle.");

    win_priority_a: assert property (
        !(win1Active && win2Active))
        else $error("Both windows active at once.");

    size_disable_a: assert property (
        ($past(st.size1) == SZ_OFF) |-> !win1Active)
        else $error("Disabled window one reported a hit.");

    pin_owner_a: assert property (
        ##1 pinOe == ($past(st.lineAssign) | $past(gpioOe)))
        else $error("Pin enable does not follow assignment.");

    bank_drive_a: assert property (
        (st.size1 == SZ_8K && cpuAddr[15:13] == st.base1
         && !cpuVectorFetch && st.lineAssign[5])
        |=> win1Active && pinOut[5] == $past(st.bank1[5])
            && memAddr[12:0] == $past(cpuAddr[12:0]))
        else $error("Bank number not driven for window one.");

    mid_invert_a: assert property (
        (st.size1 == SZ_32K && st.base1[2:1] == MID_BASE_MSB
         && cpuAddr[15:14] == 2'h1 && !cpuVectorFetch && st.lineAssign[1])
        |=> pinOut[1] == !$past(cpuAddr[14]))
        else $error("Bit 14 not inverted for midpoint window.");

    internal_serve_a: assert property (
        onChipHit |=> onChipSel && !externalSel)
        else $error("Internal access went external.");

    rom_bank_a: assert property (
        (romHit && !onChipHit && !cpuVectorFetch && selHit1
         && st.bank1[5:3] != 3'h0) |=> externalSel)
        else $error("ROM served in a high bank.");

    vector_ext_a: assert property (
        (cpuVectorFetch && st.expEn && !st.romEn)
        |=> memAddr[15:1] == VEC_EXT_ADDR[15:1] && externalSel)
        else $error("External vector address wrong.");

    unused_line_a: assert property (
        (st.lineAssign[0] && st.size1 == SZ_OFF && st.size2 == SZ_OFF
         && !cpuVectorFetch) |=> pinOut[0] == $past(cpuAddr[13]))
        else $error("Unused line lost the CPU bit.");

    win1_cov_c: cover property (win1Active);
    win2_cov_c: cover property (win2Active);
    rom_ext_c:  cover property (romHit ##1 externalSel);
    wr_cov_c:   cover property (wb_cyc_i && wb_stb_i && wb_we_i ##1 wb_ack_o);

endmodule
`default_nettype wire

// ===== testbench/pmwe_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmwe_mem_model (
    input  wire logic [pmwe_pkg::NUM_LINES-1:0] pinOut,
    input  wire logic [pmwe_pkg::NUM_LINES-1:0] pinOe,
    input  wire logic [pmwe_pkg::NUM_LINES-1:0] extLevel,
    input  wire logic [pmwe_pkg::CPU_AW-1:0]    memAddr,
    output logic      [pmwe_pkg::NUM_LINES-1:0] pinLevel,
    output logic      [18:0]                    extAddr
);
    import pmwe_pkg::*;
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
    assign extAddr = {pinLevel[5:3], memAddr};
endmodule
`default_nettype wire

// ===== testbench/tb_paged_memory_window_expansion.sv
`timescale 1ns/10ps
`default_nettype none
module tb_paged_memory_window_expansion;
    import pmwe_pkg::*;
    typedef struct packed {
        logic g; logic [5:0] gio; logic [15:0] ma; logic [5:0] po, oe;
        logic ex, on, w1, w2;
    } pmwe_note_s;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, probe = 1'b0, pSeen = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, datO;
    logic        ack, exSel, onSel, w1, w2, vf = 1'b0, och = 1'b0, rom = 1'b0;
    logic [15:0] cpuA = 16'h0, memA, seed = 16'h0055;
    logic [5:0]  gDrv = 6'h0, gOe = 6'h0, extLvl = 6'h0, pinLvl, gIn, pOut, pOe;
    logic [5:0]  asg = 6'h0, bk1 = 6'h0, bk2 = 6'h0;
    logic [1:0]  sz1 = 2'h0, sz2 = 2'h0;
    logic [2:0]  bs1 = 3'h0, bs2 = 3'h0, ctl = 3'h1;
    logic [18:0] extA;
    int          errors = 0, numChecks = 0;
    pmwe_note_s  dq[$];
    pmwe_note_s  lastN;
    logic [31:0] rq[$];

    always #5 sys_clk = ~sys_clk;

    pmwe_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .cpuAddr(cpuA),
        .cpuVectorFetch(vf), .onChipHit(och), .romHit(rom), .gpioDrive(gDrv),
        .gpioOe(gOe), .pinIn(pinLvl), .gpioIn(gIn), .pinOut(pOut),
        .pinOe(pOe), .memAddr(memA), .externalSel(exSel), .onChipSel(onSel),
        .win1Active(w1), .win2Active(w2));
    pmwe_mem_model memModel (.pinOut(pOut), .pinOe(pOe), .extLevel(extLvl),
        .memAddr(memA), .pinLevel(pinLvl), .extAddr(extA));

    task automatic giveVerdict();
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chkVal(string nm, logic [31:0] e, logic [31:0] s);
        numChecks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chkDec(pmwe_note_s n);
        chkVal("memAddr", 32'(n.ma), 32'(memA));
        chkVal("pinOut", 32'(n.po), 32'(pOut));
        chkVal("pinOe", 32'(n.oe), 32'(pOe));
        chkVal("externalSel", 32'(n.ex), 32'(exSel));
        chkVal("onChipSel", 32'(n.on), 32'(onSel));
        chkVal("win1Active", 32'(n.w1), 32'(w1));
        chkVal("win2Active", 32'(n.w2), 32'(w2));
        if (n.g) chkVal("gpioIn", 32'(n.gio), 32'(gIn));
        chkVal("extAddr", 32'({n.gio[5:3], n.ma}), 32'(extA));
    endtask

    always @(posedge sys_clk) pSeen <= probe;
    always @(negedge sys_clk) begin
        if (pSeen && dq.size() > 0) chkDec(dq.pop_front());
        if (ack === 1'b1 && !we && rq.size() > 0)
            chkVal("read data", rq.pop_front(), datO);
    end

    function automatic logic hit(logic [1:0] s, logic [2:0] b, logic [15:0] a);
        case (s)
            SZ_8K:   return a[15:13] == b;
            SZ_16K:  return a[15:14] == b[2:1];
            SZ_32K:  return (b[2:1] == MID_BASE_MSB) ? a[15] ^ a[14]
                                                     : a[15] == b[2];
            default: return 1'b0;
        endcase
    endfunction

    function automatic pmwe_note_s refDec(logic [15:0] a, logic v, logic oc,
                                          logic rm);
        pmwe_note_s n;
        logic       h1, h2, vx, rs, mid;
        logic [1:0] s;
        logic [2:0] bw;
        logic [5:0] bk, ln;
        int         f;
        h1 = hit(sz1, bs1, a);
        h2 = hit(sz2, bs2, a) && !h1;
        s = h1 ? sz1 : (h2 ? sz2 : SZ_OFF);
        bk = h1 ? bk1 : bk2;
        bw = h1 ? bs1 : bs2;
        mid = bw[2:1] == MID_BASE_MSB;
        f = (s == SZ_8K) ? 0 : ((s == SZ_16K) ? 1 : 2);
        for (int i = 0; i < 6; i++) begin
            if (s != SZ_OFF && i >= f) ln[i] = bk[i];
            else if (s == SZ_32K && i == 1 && mid) ln[i] = ~a[14];
            else ln[i] = (i < 3) ? a[(13 + i) % 16] : 1'b0;
        end
        n.po = (asg & ln) | (~asg & gDrv);
        n.oe = asg | gOe;
        n.ma = a;
        for (int i = 0; i < 3; i++) if (asg[i]) n.ma[13 + i] = ln[i];
        vx = v && (!ctl[POS_ROM_EN] || ctl[POS_ROM_LOW]);
        if (vx && ctl[POS_EXP_EN]) n.ma = VEC_EXT_ADDR | {15'h0, a[0]};
        rs = ctl[POS_ROM_EN] && !vx && (!(h1 || h2) || bk[5:3] == 3'h0);
        n.on = oc || (rm && rs);
        n.ex = !n.on;
        n.w1 = h1;
        n.w2 = h2;
        n.gio = (n.oe & n.po) | (~n.oe & extLvl);
        n.g = 1'b0;
        return n;
    endfunction

    task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            errors++;
            giveVerdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic poke(logic [15:0] a, logic v, logic oc, logic rm, logic g);
        pmwe_note_s n;
        @(posedge sys_clk);
        cpuA <= a;
        vf <= v;
        och <= oc;
        rom <= rm;
        n = refDec(a, v, oc, rm);
        n.g = g;
        lastN = n;
        if (g) begin
            probe <= 1'b0;
            repeat (7) @(posedge sys_clk);
        end
        dq.push_back(n);
        probe <= 1'b1;
    endtask

    function automatic void rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    endfunction

    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            if (i != 6) rd(8'(i * 4), (i == 5) ? 32'h1 : 32'h0);
        wb(1'b1, OFS_BANK1, 32'h3f, 4'he);
        rd(OFS_BANK1, 32'h0);
        wb(1'b1, OFS_BANK1, 32'hffffffff, 4'hf);
        wb(1'b1, 8'h1c, 32'hffffffff, 4'hf);
        rd(OFS_BANK1, 32'h3f);
        rd(8'h1c, 32'h0);
        for (int c = 0; c < 40; c++) begin
            rnd();
            {bs2, bs1, sz2, sz1, asg} = seed;
            if (sz1 >= SZ_16K) bs1 = {bs1[2], bs1[1] & ~bs1[2], 1'b0};
            if (sz2 >= SZ_16K) bs2 = {bs2[2], bs2[1] & ~bs2[2], 1'b0};
            rnd();
            {bk2, bk1} = seed[11:0];
            gDrv <= seed[5:0];
            rnd();
            gOe <= seed[5:0];
            extLvl <= seed[11:6];
            wb(1'b1, OFS_LINE_ASSIGN, {26'h0, asg}, 4'hf);
            wb(1'b1, OFS_WIN_SIZE, {28'h0, sz2, sz1}, 4'hf);
            wb(1'b1, OFS_WIN_BASE, {25'h0, bs2, 1'b0, bs1}, 4'hf);
            wb(1'b1, OFS_BANK1, {26'h0, bk1}, 4'hf);
            wb(1'b1, OFS_BANK2, {26'h0, bk2}, 4'hf);
            rd(OFS_WIN_SIZE, {28'h0, sz2, sz1});
            for (int p = 0; p < 16; p++) begin
                rnd();
                poke(seed, 1'b0, seed[3] & seed[7], seed[9], p == 0);
            end
            rd(OFS_STATUS, 32'({lastN.on, lastN.ex, lastN.w2, lastN.w1}));
        end
        {asg, sz1, sz2} = '0;
        wb(1'b1, OFS_LINE_ASSIGN, 32'h0, 4'hf);
        wb(1'b1, OFS_WIN_SIZE, 32'h0, 4'hf);
        for (int m = 0; m < 8; m++) begin
            ctl = 3'(m);
            wb(1'b1, OFS_CONTROL, {29'h0, ctl}, 4'hf);
            poke(16'hfffe | 16'(m & 1), 1'b1, 1'b0, 1'b1, 1'b1);
            poke(16'he000, 1'b0, 1'b0, 1'b1, 1'b0);
        end
        @(posedge sys_clk);
        probe <= 1'b0;
        repeat (3) @(posedge sys_clk);
        giveVerdict();
    end
endmodule
`default_nettype wire
